// >>> include/eeprom_map.vh
// constants for the two-wire serial eeprom slave core
// assumes a 100 MHz system clock sampling the bus pins
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// array organisation
`define ADDR_W          11
`define MEM_WORDS       2048
`define PAGE_W          4
`define PAGE_BYTES      16
`define BYTE_W          8

// slave address byte
`define DEV_CODE        4'ha
`define READ_BIT        1'b1
`define DEV_CODE_HI     7
`define DEV_CODE_LO     4
`define BLK_HI          3
`define BLK_LO          1
`define RW_POS          0

// bit counting
`define CNT_W           3
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define CNT_LAST        3'h7

// programming time
`define PROG_TIME_NS    5000000
`define CLOCK_PERIOD_NS 10
`define PROG_CNT_W      20

// staging fifo
`define FIFO_WIDTH      19
`define FIFO_DEPTH      4
`define FIFO_AW         2

`endif

// >>> src/stage_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable
`include "eeprom_map.vh"
module stage_fifo #(
   parameter WIDTH = `FIFO_WIDTH,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW    = `FIFO_AW
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst,
   input  wire             ce,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   localparam [AW:0] FULL_COUNT = DEPTH;

   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != FULL_COUNT);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = store[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            store[wr_ptr] <= in_data;
            wr_ptr        <= wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule // stage_fifo

// >>> src/eeprom_slave_core.v
// two-wire serial eeprom slave: bus engine, page buffer, array, write timer
// assumes SCL/SDA already synchronous to CLOCK; SDA wire resolved outside
//
// Operation
// - 2048 bytes in 16-byte pages; page writes stay in one page.
// - partial page writes program only the bytes received.
// - programming runs self-timed and ends within 5 ms.
// - protect input high blocks new writes; a programming already requested or running still commits.
// - protect input low permits normal writes; floating (z) compares as x and blocks them.
// - bus ignored during power-on reset; then standby.
// - Stop gives standby now, or after programming ends.
// - select inputs are not used for address matching.
// - data line only pulled low or released.
// - address byte is 1010, three block bits, then read bit.
// - page write increments low four address bits only, wrapping.
// - no acknowledge to address bytes while programming.
// - address counter points one past last byte, wraps to zero.
`include "eeprom_map.vh"
module eeprom_slave_core #(
   parameter PROG_CYCLES = `PROG_TIME_NS / `CLOCK_PERIOD_NS
) (
   // clock, reset, enable
   input  wire CLOCK,
   input  wire RST,
   input  wire CE,
   // two-wire bus
   input  wire SCL_IN,
   input  wire SDA_IN,
   output reg  SDA_OUT,
   output reg  SDA_OE,
   // straps
   input  wire WRITE_PROTECT,
   input  wire SELECT_INPUT_ZERO,
   input  wire SELECT_INPUT_ONE,
   input  wire SELECT_INPUT_TWO,
   // status
   output reg  BUSY
);
   localparam S_IDLE = 3'h0;
   localparam S_RX   = 3'h1;
   localparam S_ACK  = 3'h2;
   localparam S_TX   = 3'h3;
   localparam S_MACK = 3'h4;
   localparam S_LOAD = 3'h5;

   localparam K_DEV  = 2'h0;
   localparam K_WORD = 2'h1;
   localparam K_DATA = 2'h2;

   reg [`BYTE_W-1:0]     mem [0:`MEM_WORDS-1];
   reg [2:0]             st;
   reg [1:0]             kind;
   reg [`CNT_W-1:0]      cnt;
   reg [`BYTE_W-1:0]     shreg;
   reg [`BYTE_W-1:0]     txreg;
   reg [2:0]             blk;
   reg                   rd;
   reg [`ADDR_W-1:0]     addr;
   reg                   scl_q;
   reg                   sda_q;
   reg                   prog_req;
   reg [`PROG_CNT_W-1:0] prog_cnt;
   reg [`ADDR_W-1:`PAGE_W] pg_base;
   reg [`BYTE_W-1:0]     pg_data [0:`PAGE_BYTES-1];
   reg [`PAGE_BYTES-1:0] pg_valid;

   wire [`BYTE_W-1:0]    full_byte = {shreg[`BYTE_W-2:0], SDA_IN};
   wire scl_rise  = SCL_IN & ~scl_q;
   wire scl_fall  = ~SCL_IN & scl_q;
   wire start_det = scl_q & SCL_IN & sda_q & ~SDA_IN;
   wire stop_det  = scl_q & SCL_IN & ~sda_q & SDA_IN;
   wire engaged   = BUSY | prog_req;
   wire protect   = (WRITE_PROTECT == 1'b1);
   wire [`PAGE_W-1:0] prog_idx = prog_cnt[`PAGE_W-1:0];
   wire prog_end  = (prog_cnt == PROG_CYCLES - 1);

   // staging fifo between the bus engine and the page buffer
   reg                   f_in_valid;
   reg [`FIFO_WIDTH-1:0] f_in_data;
   wire                  f_in_ready;
   wire                  f_out_valid;
   wire [`FIFO_WIDTH-1:0] f_out_data;
   wire                  f_out_ready = ~BUSY;
   wire [`ADDR_W-1:0]    f_addr = f_out_data[`FIFO_WIDTH-1:`BYTE_W];
   wire [`PAGE_W-1:0]    f_idx  = f_addr[`PAGE_W-1:0];

   stage_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk       (CLOCK),
      .rst       (RST),
      .ce        (CE),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // page buffer entries, one per byte of the page
   genvar g;
   generate
      for (g = 0; g < `PAGE_BYTES; g = g + 1) begin : page_entry
         always @(posedge CLOCK) begin
            if (RST) begin
               pg_valid[g] <= 1'b0;
               pg_data[g]  <= {`BYTE_W{1'b0}};
            end else if (CE) begin
               if (f_out_valid & f_out_ready & (f_idx == g)) begin
                  pg_data[g]  <= f_out_data[`BYTE_W-1:0];
                  pg_valid[g] <= 1'b1;
               end else if (BUSY & prog_end)
                  pg_valid[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // page base follows the bytes that arrive; all of one page
   always @(posedge CLOCK) begin
      if (RST)
         pg_base <= {(`ADDR_W-`PAGE_W){1'b0}};
      else if (CE & f_out_valid & f_out_ready)
         pg_base <= f_addr[`ADDR_W-1:`PAGE_W];
   end

   // array commit during the first cycles of the programming window
   always @(posedge CLOCK) begin
      if (CE & BUSY & (prog_cnt < `PAGE_BYTES) & pg_valid[prog_idx])
         mem[{pg_base, prog_idx}] <= pg_data[prog_idx];
   end

   // self-timed programming window
   always @(posedge CLOCK) begin
      if (RST) begin
         BUSY     <= 1'b0;
         prog_req <= 1'b0;
         prog_cnt <= {`PROG_CNT_W{1'b0}};
      end else if (CE) begin
         if (BUSY) begin
            prog_cnt <= prog_cnt + 1'b1;
            if (prog_end)
               BUSY <= 1'b0;
         end else if (prog_req & ~f_out_valid) begin
            prog_req <= 1'b0;
            prog_cnt <= {`PROG_CNT_W{1'b0}};
            BUSY     <= (pg_valid != {`PAGE_BYTES{1'b0}});
         end else if (stop_det & ~protect & (kind == K_DATA) & ~rd)
            prog_req <= 1'b1;
      end
   end

   // bus engine
   always @(posedge CLOCK) begin
      if (RST) begin
         st         <= S_IDLE;
         kind       <= K_DEV;
         cnt        <= `CNT_ZERO;
         shreg      <= {`BYTE_W{1'b0}};
         txreg      <= {`BYTE_W{1'b0}};
         blk        <= 3'h0;
         rd         <= 1'b0;
         addr       <= {`ADDR_W{1'b0}};
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         SDA_OUT    <= 1'b0;
         SDA_OE     <= 1'b0;
         f_in_valid <= 1'b0;
         f_in_data  <= {`FIFO_WIDTH{1'b0}};
      end else if (CE) begin
         scl_q      <= SCL_IN;
         sda_q      <= SDA_IN;
         f_in_valid <= 1'b0;
         if (start_det) begin
            st     <= S_RX;
            kind   <= K_DEV;
            cnt    <= `CNT_ZERO;
            SDA_OE <= 1'b0;
         end else if (stop_det) begin
            st     <= S_IDLE;
            SDA_OE <= 1'b0;
         end else begin
            case (st)
               S_RX: begin
                  if (scl_rise) begin
                     shreg <= full_byte;
                     cnt   <= cnt + `CNT_ONE;
                     if (cnt == `CNT_LAST) begin
                        st <= S_ACK;
                        case (kind)
                           K_DEV: begin
                              // select inputs play no part in the match
                              if ((full_byte[`DEV_CODE_HI:`DEV_CODE_LO] != `DEV_CODE) | engaged)
                                 st <= S_IDLE;
                              blk <= full_byte[`BLK_HI:`BLK_LO];
                              rd  <= (full_byte[`RW_POS] == `READ_BIT);
                           end
                           K_WORD: addr <= {blk, full_byte};
                           K_DATA: begin
                              if (~protect) begin
                                 if (f_in_ready) begin
                                    f_in_valid <= 1'b1;
                                    f_in_data  <= {addr, full_byte};
                                    addr[`PAGE_W-1:0] <= addr[`PAGE_W-1:0] + 1'b1;
                                 end else
                                    st <= S_IDLE;
                              end
                           end
                           default: st <= S_IDLE;
                        endcase
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (~SDA_OE)
                        SDA_OE <= 1'b1;
                     else begin
                        SDA_OE <= 1'b0;
                        cnt    <= `CNT_ZERO;
                        if (rd & (kind == K_DEV))
                           st <= S_LOAD;
                        else begin
                           st   <= S_RX;
                           kind <= (kind == K_DEV) ? K_WORD : K_DATA;
                        end
                     end
                  end
               end
               S_LOAD: begin
                  txreg  <= mem[addr];
                  SDA_OE <= ~mem[addr][`BYTE_W-1];
                  addr   <= addr + 1'b1;
                  cnt    <= `CNT_ZERO;
                  st     <= S_TX;
               end
               S_TX: begin
                  if (scl_fall) begin
                     cnt <= cnt + `CNT_ONE;
                     if (cnt == `CNT_LAST) begin
                        SDA_OE <= 1'b0;
                        st     <= S_MACK;
                     end else begin
                        txreg  <= {txreg[`BYTE_W-2:0], 1'b0};
                        SDA_OE <= ~txreg[`BYTE_W-2];
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise & SDA_IN)
                     st <= S_IDLE;
                  else if (scl_fall)
                     st <= S_LOAD;
               end
               default: begin
                  st     <= S_IDLE;
                  SDA_OE <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // eeprom_slave_core

// >>> test/eeprom_slave_core_assertions.sv
// port checker for the two-wire eeprom slave core
// assumes one clock and a synchronous active-high reset
module eeprom_slave_core_assertions #(
   parameter PROG_CYCLES = 40
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   // bus and status
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic WRITE_PROTECT,
   input wire logic BUSY
);
   timeunit 1ns;
   timeprecision 100ps;
   int   busy_cnt = 0;
   logic rst_q    = 1'b1;
   always @(posedge CLOCK) begin
      rst_q <= RST;
      // only enabled edges advance the programming window
      if (!BUSY)
         busy_cnt <= 0;
      else if (CE)
         busy_cnt <= busy_cnt + 1;
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   sequence prog_window;
      BUSY [*8];
   endsequence
   chk_drain_only: assert property (SDA_OUT == 1'b0)
      else $error("data line driven high");
   chk_reset_idle: assert property (rst_q |-> !BUSY && !SDA_OE)
      else $error("not idle after reset");
   chk_busy_length: assert property ($fell(BUSY) |-> busy_cnt == PROG_CYCLES)
      else $error("programming window length wrong");
   chk_prog_hold: assert property ($rose(BUSY) |-> prog_window)
      else $error("busy flag dropped early");
   chk_busy_silent: assert property (BUSY |-> !SDA_OE)
      else $error("bus answered while programming");
   chk_protect_idle: assert property ($rose(BUSY) |-> !WRITE_PROTECT)
      else $error("programming started while protected");
   chk_oe_steady: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
      else $error("data line moved while clock high");
   chk_oe_low_scl: assert property ($rose(SDA_OE) |-> !SCL_IN && !$past(SCL_IN))
      else $error("pull-down began outside clock low");
endmodule // eeprom_slave_core_assertions

bind eeprom_slave_core eeprom_slave_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk (
   .CLOCK(CLOCK), .RST(RST), .CE(CE), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));

// >>> test/two_wire_master.sv
// behavioural two-wire bus master
// assumes a pulled-up data line; the device only pulls it low
module two_wire_master (
   // clock
   input  wire logic clk,
   // bus
   input  wire logic dev_oe,
   output logic      scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic low = 1'b0;
   initial scl = 1'b1;
   assign sda = ~(dev_oe | low);
   // 50 clocks per half period keeps scl at 1 MHz
   task tick;
      repeat (50) @(posedge clk);
      #1;
   endtask
   task clk_bit(input logic b, output logic s);
      low = ~b;
      tick();
      scl = 1'b1;
      tick();
      s   = sda;
      scl = 1'b0;
   endtask
   task start;
      low = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      low = 1'b1;
      tick();
      scl = 1'b0;
   endtask
   task stop;
      low = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      low = 1'b0;
      tick();
   endtask
   task put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask
   task get(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++) begin
         clk_bit(1'b1, s);
         d = {d[6:0], s};
      end
      clk_bit(last, s);
   endtask
endmodule // two_wire_master

// >>> test/serial_eeprom_slave_core_tb.sv
// self-checking bench for the two-wire eeprom slave core
// assumes the master model and the bound checker are compiled first
module serial_eeprom_slave_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PROG  = 1500;
   localparam int LIMIT = 90000;
   logic       clk = 1'b0, rst = 1'b1, wp = 1'b0, ce = 1'b1, ack;
   logic [2:0] sel = 3'h0;
   logic [7:0] rdata;
   wire logic  scl, sda, sda_out, sda_oe, busy;
   int         mismatches = 0, n_compared = 0, cycles = 0;
   int         run = 0, busy_len = 0, windows = 0;
   // select straps, address, data
   logic [21:0] rows [4] = '{{3'h0, 11'h000, 8'h3c}, {3'h5, 11'h7ff, 8'hc3},
                             {3'h2, 11'h123, 8'h11}, {3'h7, 11'h124, 8'h22}};
   always #5 clk = ~clk;
   eeprom_slave_core #(.PROG_CYCLES(PROG)) uut (
      .CLOCK(clk), .RST(rst), .CE(ce), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
      .SDA_OE(sda_oe), .WRITE_PROTECT(wp), .SELECT_INPUT_ZERO(sel[0]),
      .SELECT_INPUT_ONE(sel[1]), .SELECT_INPUT_TWO(sel[2]), .BUSY(busy));
   two_wire_master m (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
   task tally_and_finish;
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task wr(input logic [10:0] a, input logic [7:0] d, input int n);
      m.start();
      m.put({4'ha, a[10:8], 1'b0}, ack);
      check(ack, 1'b1);
      m.put(a[7:0], ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.put(d + 8'(i), ack);
         check(ack, 1'b1);
      end
      m.stop();
   endtask
   task rd(input logic [10:0] a, output logic [7:0] d);
      m.start();
      m.put({4'ha, a[10:8], 1'b0}, ack);
      m.put(a[7:0], ack);
      m.start();
      m.put({4'ha, a[10:8], 1'b1}, ack);
      check(ack, 1'b1);
      m.get(1'b1, d);
      m.stop();
   endtask
   // busy run length, recorded each time a window closes
   always @(posedge clk) begin
      run <= (busy === 1'b1) ? run + 1 : 0;
      if (busy !== 1'b1 && run != 0) begin
         busy_len <= run;
         windows  <= windows + 1;
      end
   end
   // want < 0 only drains a window already running
   task wait_idle(input int want);
      int w, k;
      w = windows;
      k = 0;
      while ((busy === 1'b1 || run != 0) && k < PROG + 10) begin
         @(posedge clk);
         #1 k++;
      end
      if (want > 0) check(16'(busy_len), 16'(want));
      if (want >= 0) check(16'(windows - w), (want > 0) ? 16'h1 : 16'h0);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge clk);
      #1 check({sda_oe, busy}, 2'b00);
      foreach (rows[i]) begin
         sel = rows[i][21:19];
         wr(rows[i][18:8], rows[i][7:0], 1);
         wait_idle(PROG);
         rd(rows[i][18:8], rdata);
         check(rdata, rows[i][7:0]);
      end
      rd(11'h123, rdata);
      check(rdata, 8'h11);
      wr(11'h35e, 8'h50, 3);
      m.start();
      m.put(8'ha0, ack);
      check({ack, busy}, 2'b01);
      m.stop();
      // frozen past the window's natural end, busy must still stand
      ce = 1'b0;
      repeat (400) @(posedge clk);
      #1 check({busy, sda_oe}, 2'b10);
      ce = 1'b1;
      wait_idle(-1);
      for (int i = 0; i < 3; i++) begin
         rd({7'h35, 4'(14 + i)}, rdata);
         check(rdata, 8'h50 + 8'(i));
      end
      wp = 1'b1;
      wr(11'h35e, 8'haa, 1);
      wait_idle(0);
      wp = 1'b0;
      rd(11'h35e, rdata);
      check(rdata, 8'h50);
      rd(11'h7ff, rdata);
      m.start();
      m.put(8'ha1, ack);
      m.get(1'b1, rdata);
      m.stop();
      check(rdata, 8'h3c);
      m.start();
      m.put(8'h50, ack);
      m.stop();
      check(ack, 1'b0);
      rst = 1'b1;
      m.start();
      m.put(8'ha0, ack);
      m.stop();
      check(ack, 1'b0);
      rst = 1'b0;
      // after reset the address counter is back at zero
      m.start();
      m.put(8'ha1, ack);
      m.get(1'b1, rdata);
      m.stop();
      check({ack, rdata}, {1'b1, 8'h3c});
      tally_and_finish();
   end
endmodule // serial_eeprom_slave_core_tb
